// ==== dps_pkg.sv ====
// Purpose: constants for the detail preamble signalling framer
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   field widths are implementation choices
//
// What this block does
// RULE_01 - send a four-bit structure edition field in every frame
// RULE_02 - reserved bits carry software content; edition unchanged by that
// RULE_03 - bonded stream count excludes the stream being transmitted
// RULE_04 - seconds and milliseconds sent only with time flag, always together
// RULE_05 - micro and nano parts nest under coarser parts and the time flag
// RULE_06 - mixed flag set forces all-multi-antenna flag clear for that subframe
// RULE_07 - subframe symbol count sent as symbols minus one
// RULE_08 - subframe pipe count sent as pipes minus one
// RULE_09 - pipe identifier limited to zero through sixty-three
// RULE_10 - low-level-signalling flag taken per identifier, same in every subframe
// RULE_11 - one carrier reduction value per subframe, covering all its symbols
// RULE_12 - enhanced layer pipe repeats the interleave mode of its core pipe
// RULE_13 - modulation code uses one code set for single and multi antenna
// RULE_14 - pipe bonded channel count excludes the present channel, zero means none
// RULE_15 - bonding format bit selects plain or averaging bonding
// RULE_16 - per-subframe bit tells frequency interleaver enabled or bypassed
// RULE_17 - two-bit time flag gives presence and precision of time fields
// RULE_18 - block ends with CRC-32 over all preceding bits
// RULE_19 - subframe group once per subframe, pipe group count-plus-one times

package dps_pkg;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADR_CTRL  = 8'h00;
    localparam logic [7:0] ADR_FRAME = 8'h04;
    localparam logic [7:0] ADR_TSEC  = 8'h08;
    localparam logic [7:0] ADR_TSUB  = 8'h0C;
    localparam logic [7:0] ADR_SFSEL = 8'h10;
    localparam logic [7:0] ADR_SFDAT = 8'h14;
    localparam logic [7:0] ADR_PSEL  = 8'h18;
    localparam logic [7:0] ADR_PDAT  = 8'h1C;
    localparam logic [7:0] ADR_LLS0  = 8'h20;
    localparam logic [7:0] ADR_LLS1  = 8'h24;
    localparam logic [7:0] ADR_CRC   = 8'h28;

    // ****************************************************************
    // register masks, checksum start value and polynomial
    // ****************************************************************
    localparam logic [31:0] FRAME_MASK = 32'hFFFF_777F;
    localparam logic [31:0] TSUB_MASK  = 32'h3FFF_FFFF;
    localparam logic [31:0] SF_MASK    = 32'h01FF_FFFF;
    localparam logic [31:0] PIPE_MASK  = 32'h0001_FFFF;
    localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY   = 32'h04C1_1DB7;

    // ****************************************************************
    // field widths on the serial stream
    // ****************************************************************
    localparam logic [5:0] W_EDITION = 6'h04;
    localparam logic [5:0] W_BOND    = 6'h03;
    localparam logic [5:0] W_SEC     = 6'h20;
    localparam logic [5:0] W_SUBSEC  = 6'h0A;
    localparam logic [5:0] W_RSVD    = 6'h10;
    localparam logic [5:0] W_FLAG    = 6'h01;
    localparam logic [5:0] W_CRED    = 6'h03;
    localparam logic [5:0] W_NSYM    = 6'h0B;
    localparam logic [5:0] W_NPIPE   = 6'h06;
    localparam logic [5:0] W_PID     = 6'h06;
    localparam logic [5:0] W_MOD     = 6'h04;
    localparam logic [5:0] W_TI      = 6'h02;
    localparam logic [5:0] W_CRC     = 6'h20;

    // time flag codes
    localparam logic [1:0] TF_NONE = 2'h0;
    localparam logic [1:0] TF_US   = 2'h2;
    localparam logic [1:0] TF_NS   = 2'h3;

    // last step index of each field group
    localparam logic [2:0] HDR_LAST  = 3'h6;
    localparam logic [2:0] SF_LAST   = 3'h5;
    localparam logic [2:0] PIPE_LAST = 3'h5;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR  = 3'b001,
        ST_SF   = 3'b011,
        ST_PIPE = 3'b010,
        ST_CRC  = 3'b110
    } dps_state_e;

endpackage

// ==== dps_detail_framer.sv ====
// Purpose: serialises detail preamble signalling of one frame
// Assumes: tables loaded over Wishbone before start
// Notes:   one stream bit per cycle, MSB first, bubble between fields

`timescale 1ns/1ps
`default_nettype none

module dps_detail_framer
    import dps_pkg::*;
#(
    parameter int SF_AW = 3,
    parameter int P_AW  = 6
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [31:0] WB_DAT_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic        WB_WE_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             DET_BIT,
    output logic             DET_VALID,
    output logic             DET_LAST,
    output logic             DET_BUSY
);

    if (SF_AW < 1 || SF_AW > 3 || P_AW < 1 || P_AW > 6) begin : g_chk
        $error("dps_detail_framer: table address width out of range");
    end

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [31:0]      sf_mem [2**SF_AW];
    logic [31:0]      p_mem  [2**P_AW];
    logic [31:0]      frame_r;
    logic [31:0]      tsec_r;
    logic [31:0]      tsub_r;
    logic [63:0]      lls_r;
    logic [SF_AW-1:0] sfsel_r;
    logic [P_AW-1:0]  psel_r;
    logic [31:0]      crc_last_r;
    logic [7:0]       frm_cnt_r;

    dps_state_e       state_r;
    logic [2:0]       step_r;
    logic [SF_AW-1:0] sf_r;
    logic [5:0]       pn_r;
    logic [P_AW-1:0]  pp_r;
    logic [31:0]      sh_r;
    logic [5:0]       left_r;
    logic [31:0]      crc_r;
    logic [1:0]       core_ti_r;

    // ****************************************************************
    // bus decode
    // ****************************************************************
    logic       wb_hit;
    logic       wr;
    logic       cfg_wr;
    logic [7:0] wa;
    logic       start_p;

    assign wb_hit  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wr      = wb_hit && WB_WE_I;
    assign wa      = {WB_ADR_I[7:2], 2'b00};
    // config is frozen while a frame is being sent
    assign cfg_wr  = wr && (state_r == ST_IDLE);
    assign start_p = cfg_wr && (wa == ADR_CTRL) && WB_SEL_I[0] && WB_DAT_I[0];

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[8*i +: 8] = n[8*i +: 8];
            end
        end
        return m;
    endfunction

    // count minus one, held at zero
    function automatic logic [11:0] dec_sat(input logic [11:0] v);
        return (v == 12'h000) ? 12'h000 : v - 12'h001;
    endfunction

    // ****************************************************************
    // register writes
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            frame_r <= 32'h0000_0000;
            tsec_r  <= 32'h0000_0000;
            tsub_r  <= 32'h0000_0000;
            lls_r   <= 64'h0000_0000_0000_0000;
            sfsel_r <= '0;
            psel_r  <= '0;
        end else if (cfg_wr) begin
            unique case (wa)
                ADR_FRAME: frame_r <= merge(frame_r, WB_DAT_I, WB_SEL_I) & FRAME_MASK;
                ADR_TSEC:  tsec_r  <= merge(tsec_r, WB_DAT_I, WB_SEL_I);
                ADR_TSUB:  tsub_r  <= merge(tsub_r, WB_DAT_I, WB_SEL_I) & TSUB_MASK;
                ADR_SFSEL: sfsel_r <= WB_SEL_I[0] ? WB_DAT_I[SF_AW-1:0] : sfsel_r;
                ADR_PSEL:  psel_r  <= WB_SEL_I[0] ? WB_DAT_I[P_AW-1:0] : psel_r;
                ADR_LLS0:  lls_r[31:0]  <= merge(lls_r[31:0], WB_DAT_I, WB_SEL_I);
                ADR_LLS1:  lls_r[63:32] <= merge(lls_r[63:32], WB_DAT_I, WB_SEL_I);
                default: ;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (cfg_wr && wa == ADR_SFDAT) begin
            sf_mem[sfsel_r] <= merge(sf_mem[sfsel_r], WB_DAT_I, WB_SEL_I) & SF_MASK;
        end
        if (cfg_wr && wa == ADR_PDAT) begin
            p_mem[psel_r] <= merge(p_mem[psel_r], WB_DAT_I, WB_SEL_I) & PIPE_MASK;
        end
    end

    // ****************************************************************
    // bus answer: one wait state, unmapped reads zero
    // ****************************************************************
    logic [31:0] rdata;

    always_comb begin
        unique case (wa)
            ADR_CTRL:  rdata = {16'h0000, frm_cnt_r, 7'h00, state_r != ST_IDLE};
            ADR_FRAME: rdata = frame_r;
            ADR_TSEC:  rdata = tsec_r;
            ADR_TSUB:  rdata = tsub_r;
            ADR_SFSEL: rdata = 32'(sfsel_r);
            ADR_SFDAT: rdata = sf_mem[sfsel_r];
            ADR_PSEL:  rdata = 32'(psel_r);
            ADR_PDAT:  rdata = p_mem[psel_r];
            ADR_LLS0:  rdata = lls_r[31:0];
            ADR_LLS1:  rdata = lls_r[63:32];
            ADR_CRC:   rdata = crc_last_r;
            default:   rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_hit;
            WB_DAT_O <= (wb_hit && !WB_WE_I) ? rdata : 32'h0000_0000;
        end
    end

    // ****************************************************************
    // field view of the current table entries
    // ****************************************************************
    logic [31:0] sfw;
    logic [31:0] pw;
    logic [1:0]  tflag;
    logic [2:0]  nsub_m1;
    logic [11:0] sf_nsym;
    logic [6:0]  sf_np;
    logic        sf_mixed;
    logic [5:0]  pn_m1;
    logic [5:0]  p_id;
    logic        p_enh;
    logic [2:0]  p_chan;

    assign sfw      = sf_mem[sf_r];
    assign pw       = p_mem[pp_r];
    assign tflag    = frame_r[5:4];
    assign nsub_m1  = frame_r[14:12];
    assign sf_mixed = sfw[1];
    assign sf_nsym  = sfw[16:5];
    assign sf_np    = sfw[24:18];
    assign pn_m1    = 6'(dec_sat({5'h00, sf_np}));
    assign p_id     = pw[5:0];
    assign p_enh    = pw[12];
    assign p_chan   = pw[15:13];

    // ****************************************************************
    // next field selection
    // ****************************************************************
    logic [31:0] f_val;
    logic [5:0]  f_w;
    logic        f_use;
    logic        ld;

    always_comb begin
        f_val = 32'h0000_0000;
        f_w   = W_FLAG;
        f_use = 1'b0;
        unique case (state_r)
            ST_HDR: begin
                f_use = 1'b1;
                unique case (step_r)
                    3'h0: begin f_val = 32'(frame_r[3:0]); f_w = W_EDITION; end // [RULE_01]
                    3'h1: begin // [RULE_03]
                        f_val = 32'(3'(dec_sat({9'h000, frame_r[10:8]})));
                        f_w   = W_BOND;
                    end
                    3'h2: begin // [RULE_04] [RULE_17]
                        f_val = tsec_r;
                        f_w   = W_SEC;
                        f_use = (tflag != TF_NONE);
                    end
                    3'h3: begin // [RULE_04]
                        f_val = 32'(tsub_r[9:0]);
                        f_w   = W_SUBSEC;
                        f_use = (tflag != TF_NONE);
                    end
                    3'h4: begin // [RULE_05]
                        f_val = 32'(tsub_r[19:10]);
                        f_w   = W_SUBSEC;
                        f_use = (tflag >= TF_US);
                    end
                    3'h5: begin // [RULE_05]
                        f_val = 32'(tsub_r[29:20]);
                        f_w   = W_SUBSEC;
                        f_use = (tflag == TF_NS);
                    end
                    // reserved space filled by software [RULE_02]
                    default: begin f_val = 32'(frame_r[31:16]); f_w = W_RSVD; end
                endcase
            end
            ST_SF: begin
                f_use = 1'b1;
                unique case (step_r)
                    3'h0: f_val = 32'(sfw[0] && !sf_mixed); // [RULE_06]
                    3'h1: f_val = 32'(sf_mixed); // [RULE_06]
                    3'h2: begin f_val = 32'(sfw[4:2]); f_w = W_CRED; end // [RULE_11]
                    3'h3: begin // [RULE_07]
                        f_val = 32'(11'(dec_sat(sf_nsym)));
                        f_w   = W_NSYM;
                    end
                    3'h4: f_val = 32'(sfw[17]); // [RULE_16]
                    default: begin f_val = 32'(pn_m1); f_w = W_NPIPE; end // [RULE_08]
                endcase
            end
            ST_PIPE: begin
                f_use = 1'b1;
                unique case (step_r)
                    3'h0: begin f_val = 32'(p_id); f_w = W_PID; end // [RULE_09]
                    3'h1: f_val = 32'(lls_r[p_id]); // [RULE_10]
                    3'h2: begin f_val = 32'(pw[9:6]); f_w = W_MOD; end // [RULE_13]
                    3'h3: begin // [RULE_12]
                        f_val = 32'(p_enh ? core_ti_r : pw[11:10]);
                        f_w   = W_TI;
                    end
                    3'h4: begin // [RULE_14]
                        f_val = 32'(3'(dec_sat({9'h000, p_chan})));
                        f_w   = W_BOND;
                    end
                    default: begin // [RULE_15]
                        f_val = 32'(pw[16]);
                        f_use = (p_chan > 3'h1);
                    end
                endcase
            end
            ST_CRC: begin
                f_val = crc_r;
                f_w   = W_CRC;
                f_use = (step_r == 3'h0); // [RULE_18]
            end
            default: ;
        endcase
    end

    assign ld = (left_r == 6'h00) && f_use;

    // ****************************************************************
    // shifter and checksum
    // ****************************************************************
    logic [31:0] crc_nxt;

    assign crc_nxt = {crc_r[30:0], 1'b0} ^ ((crc_r[31] ^ sh_r[31]) ? CRC_POLY : 32'h0000_0000);

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            sh_r   <= 32'h0000_0000;
            left_r <= 6'h00;
            crc_r  <= CRC_INIT;
        end else if (left_r != 6'h00) begin
            sh_r   <= {sh_r[30:0], 1'b0};
            left_r <= left_r - 6'h01;
            // last pipe field may still shift at checksum step zero
            if (state_r != ST_CRC || step_r == 3'h0) begin
                crc_r <= crc_nxt; // [RULE_18]
            end
        end else if (start_p) begin
            crc_r <= CRC_INIT;
        end else if (ld) begin
            sh_r   <= f_val << (6'h20 - f_w);
            left_r <= f_w;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            core_ti_r <= 2'h0;
        end else if (ld && state_r == ST_PIPE && step_r == 3'h3 && !p_enh) begin
            core_ti_r <= pw[11:10]; // [RULE_12]
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_r <= ST_IDLE;
            step_r  <= 3'h0;
            sf_r    <= '0;
            pn_r    <= 6'h00;
            pp_r    <= '0;
        end else if (left_r == 6'h00) begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_p) begin
                        state_r <= ST_HDR;
                        step_r  <= 3'h0;
                        sf_r    <= '0;
                        pp_r    <= '0;
                    end
                end
                ST_HDR: begin
                    step_r <= step_r + 3'h1;
                    if (step_r == HDR_LAST) begin
                        state_r <= ST_SF;
                        step_r  <= 3'h0;
                    end
                end
                ST_SF: begin
                    step_r <= step_r + 3'h1;
                    if (step_r == SF_LAST) begin
                        state_r <= ST_PIPE;
                        step_r  <= 3'h0;
                        pn_r    <= 6'h00;
                    end
                end
                ST_PIPE: begin
                    step_r <= step_r + 3'h1;
                    if (step_r == PIPE_LAST) begin // [RULE_19]
                        step_r <= 3'h0;
                        pp_r   <= pp_r + 1'b1;
                        pn_r   <= pn_r + 6'h01;
                        if (pn_r == pn_m1) begin
                            state_r <= (3'(sf_r) == nsub_m1) ? ST_CRC : ST_SF;
                            sf_r    <= sf_r + 1'b1;
                        end
                    end
                end
                ST_CRC: begin
                    step_r <= 3'h1;
                    if (step_r != 3'h0) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            frm_cnt_r  <= 8'h00;
            crc_last_r <= 32'h0000_0000;
        end else if (state_r == ST_CRC && ld) begin
            frm_cnt_r  <= frm_cnt_r + 8'h01;
            crc_last_r <= crc_r;
        end
    end

    // ****************************************************************
    // stream outputs
    // ****************************************************************
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            DET_BIT   <= 1'b0;
            DET_VALID <= 1'b0;
            DET_LAST  <= 1'b0;
            DET_BUSY  <= 1'b0;
        end else begin
            DET_BIT   <= (left_r != 6'h00) && sh_r[31];
            DET_VALID <= (left_r != 6'h00);
            DET_LAST  <= (left_r == 6'h01) && (state_r == ST_CRC) && (step_r != 3'h0);
            DET_BUSY  <= (state_r != ST_IDLE) || start_p;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    edition_width_a: assert property ( // [RULE_01]
        ld && state_r == ST_HDR && step_r == 3'h0 |=> left_r == 6'h04)
        else $error("edition field not four bits");
    time_nest_a: assert property ( // [RULE_05]
        ld && state_r == ST_HDR && step_r == 3'h5 |-> tflag == TF_NS ##1 left_r == 6'h0A)
        else $error("nanoseconds sent without full precision");
    time_pair_a: assert property ( // [RULE_04]
        ld && state_r == ST_HDR && step_r == 3'h2 |=> left_r == 6'h20 ##32 f_use)
        else $error("seconds not followed by milliseconds");
    mixed_excl_a: assert property ( // [RULE_06]
        ld && state_r == ST_SF && step_r == 3'h0 && sf_mixed |=> !sh_r[31])
        else $error("all-antenna flag set with mixed flag");
    sym_minus_a: assert property ( // [RULE_07]
        ld && state_r == ST_SF && step_r == 3'h3 && sf_nsym != 12'h000
        |=> {1'b0, sh_r[31:21]} + 12'h001 == $past(sf_nsym))
        else $error("symbol count not minus one");
    pipe_minus_a: assert property ( // [RULE_08]
        ld && state_r == ST_SF && step_r == 3'h5 && sf_np != 7'h00
        |=> {1'b0, sh_r[31:26]} + 7'h01 == $past(sf_np))
        else $error("pipe count not minus one");
    lls_same_a: assert property ( // [RULE_10]
        ld && state_r == ST_PIPE && step_r == 3'h1 |=> sh_r[31] == lls_r[$past(p_id)])
        else $error("low-level flag not from identifier map");
    ti_follow_a: assert property ( // [RULE_12]
        ld && state_r == ST_PIPE && step_r == 3'h3 && p_enh |=> sh_r[31:30] == $past(core_ti_r))
        else $error("enhanced pipe interleave mode differs");
    pipe_loop_a: assert property ( // [RULE_19]
        left_r == 6'h00 && state_r == ST_PIPE && step_r == PIPE_LAST && pn_r != pn_m1
        |=> state_r == ST_PIPE && pn_r == $past(pn_r) + 6'h01)
        else $error("pipe loop ended early");
    crc_tail_a: assert property ( // [RULE_18]
        state_r == ST_CRC && ld |=> left_r == 6'h20 ##32 DET_LAST ##1 !DET_VALID)
        else $error("checksum tail malformed");

    ns_frame_c: cover property (start_p && tflag == TF_NS);
    enh_pipe_c: cover property (ld && state_r == ST_PIPE && step_r == 3'h3 && p_enh);
    multi_sf_c: cover property (DET_LAST && nsub_m1 != 3'h0);
    fmt_last_c: cover property (ld && state_r == ST_PIPE && step_r == PIPE_LAST
        && pn_r == pn_m1 && 3'(sf_r) == nsub_m1);

endmodule

`default_nettype wire

// ==== dps_rx_model.sv ====
// Purpose: receiver side of the detail stream, splits it into fields
// Assumes: at least one idle cycle between fields
// Notes:   keeps value and bit count of every field, in arrival order
`timescale 1ns/1ps
`default_nettype none
module dps_rx_model (
    input  wire logic        clk,
    input  wire logic        clr,
    input  wire logic        bit_i,
    input  wire logic        valid_i,
    output logic [31:0]      val [0:63],
    output logic [5:0]       wid [0:63],
    output int               nf
);
    logic [31:0] cur;
    logic [5:0]  cnt;
    // ****************
    // field capture
    // ****************
    always_ff @(posedge clk) begin
        if (clr) begin
            nf  <= 0;
            cnt <= 6'h00;
        end else if (valid_i) begin
            cur <= (cnt == 6'h00) ? {31'h0, bit_i} : {cur[30:0], bit_i};
            cnt <= cnt + 6'h01;
        end else if (cnt != 6'h00) begin
            val[nf] <= cur;
            wid[nf] <= cnt;
            nf      <= nf + 1;
            cnt     <= 6'h00;
        end
    end
endmodule
`default_nettype wire

// ==== detail_preamble_signaling_fields_bench.sv ====
// Purpose: frames with every time flag code, checked field by field
// Assumes: pipe table read from entry 0 in each frame
// Notes:   bus tasks wait for ack, watchdog ends a hang
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module detail_preamble_signaling_fields_bench;
    import dps_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, we = 1'b0, stb = 1'b0, clr = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdat, rv [0:63];
    logic [5:0]  rw [0:63];
    logic        ack, dbit, dval, dlast, busy;
    logic [31:0] ev [$];
    int          ew [$];
    int          nf, err_total = 0, n_compared = 0;
    always #50 clk = ~clk;
    dps_detail_framer DUT (.CORE_CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(stb), .WB_STB_I(stb), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .DET_BIT(dbit), .DET_VALID(dval), .DET_LAST(dlast), .DET_BUSY(busy));
    dps_rx_model rx (.clk(clk), .clr(clr), .bit_i(dbit), .valid_i(dval), .val(rv), .wid(rw),
        .nf(nf));
    // ****************
    // bus and check tasks
    // ****************
    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w,
                      output logic [31:0] q);
        adr  <= a;
        wdat <= d;
        we   <= w;
        stb  <= 1'b1;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, d, 1'b1, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 32'h0000_0000, 1'b0, q);
        `CHK(q, e)
    endtask
    task automatic put(input logic [31:0] v, input int w);
        ev.push_back(v);
        ew.push_back(w);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic run_frame(input logic [1:0] tf, input logic [7:0] n);
        logic [31:0] crc, fw;
        int k;
        ev.delete();
        ew.delete();
        fw = {16'hBEEF, 1'b0, 3'h1, 1'b0, 3'h3, 2'h0, tf, 4'hA};
        wr(ADR_FRAME, fw);
        put(4'hA, 4); put(2, 3);
        if (tf != TF_NONE) begin put(32'h1234_5678, 32); put(10'h155, 10); end
        if (tf >= TF_US) put(10'h2AA, 10);
        if (tf == TF_NS) put(10'h0F0, 10);
        put(16'hBEEF, 16);
        put(0, 1); put(1, 1); put(5, 3); put(11'h0FF, 11); put(1, 1); put(1, 6);
        put(63, 6); put(1, 1); put(9, 4); put(2, 2); put(2, 3); put(1, 1);
        put(5, 6); put(1, 1); put(0, 4); put(2, 2); put(0, 3);
        put(1, 1); put(0, 1); put(0, 3); put(0, 11); put(0, 1); put(0, 6);
        put(0, 6); put(0, 1); put(15, 4); put(3, 2); put(1, 3); put(1, 1);
        clr <= 1'b0;
        wr(ADR_CTRL, 32'h0000_0001);
        wr(ADR_FRAME, 32'h0000_0000);
        rd(ADR_CTRL, {16'h0000, n, 8'h01});
        k = 0;
        while (dlast !== 1'b1 && k < 3000) begin @(posedge clk); k++; end
        `CHK(k < 3000, 1'b1)
        repeat (3) @(posedge clk);
        `CHK(busy, 1'b0)
        `CHK(nf, ew.size() + 1)
        crc = CRC_INIT;
        for (k = 0; k < ew.size(); k++) begin
            for (int b = ew[k] - 1; b >= 0; b--)
                crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ ev[k][b]) ? CRC_POLY : 32'h0);
            `CHK(rv[k], ev[k])
            `CHK(rw[k], 6'(ew[k]))
        end
        `CHK(rv[ew.size()], crc)
        rd(ADR_CRC, crc);
        rd(ADR_FRAME, fw & FRAME_MASK);
        rd(ADR_CTRL, {16'h0000, n + 8'h01, 8'h00});
        clr <= 1'b1;
    endtask
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ADR_CTRL, 32'h0000_0000);
        rd(8'h3C, 32'h0000_0000);
        wr(ADR_TSEC, 32'h1234_5678);
        wr(ADR_TSUB, {2'h0, 10'h0F0, 10'h2AA, 10'h155});
        wr(ADR_SFSEL, 32'h0000_0000);
        wr(ADR_SFDAT, {7'h00, 7'd2, 1'b1, 12'h100, 3'd5, 1'b1, 1'b1});
        wr(ADR_SFSEL, 32'h0000_0001);
        wr(ADR_SFDAT, {7'h00, 7'd1, 1'b0, 12'h001, 3'd0, 1'b0, 1'b1});
        wr(ADR_PSEL, 32'h0000_0000);
        wr(ADR_PDAT, {15'h0, 1'b1, 3'd3, 1'b0, 2'd2, 4'h9, 6'd63});
        wr(ADR_PSEL, 32'h0000_0001);
        wr(ADR_PDAT, {15'h0, 1'b0, 3'd1, 1'b1, 2'd1, 4'h0, 6'd5});
        wr(ADR_PSEL, 32'h0000_0002);
        wr(ADR_PDAT, {15'h0, 1'b1, 3'd2, 1'b0, 2'd3, 4'hF, 6'd0});
        wr(ADR_LLS0, 32'h0000_0020);
        wr(ADR_LLS1, 32'h8000_0000);
        for (int f = 0; f < 4; f++)
            run_frame(2'(3 - f), 8'(f));
        close_out();
    end
endmodule
`default_nettype wire
